// ---- rtl/trg_pkg.sv ----
// package for the timer run gating block: register map, field layout, timing
// assumes a single 100 MHz clock shared by bus and counter logic
package trg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_MODULO = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam int CTL_EN_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int CFG_SOO_BIT = 17;
    localparam int CFG_SOT_BIT = 16;
    localparam int CFG_GTB_BIT = 9;
    localparam int CFG_DBG_LO = 6;
    localparam int CFG_DOZE_BIT = 5;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [1:0] DBG_PAUSE = 2'h0;
    localparam logic [1:0] DBG_RUN = 2'h3;
    // status bit positions
    localparam int ST_OVF_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_STOP_BIT = 2;
    localparam int ST_PAUSE_BIT = 3;
    localparam int ST_CNT_LO = 16;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIG_DELAY_CLKS = 3;
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_ARMED = 2'b01,
        RS_COUNT = 2'b10,
        RS_STOPPED = 2'b11
    } trg_run_t;
endpackage

// ---- rtl/trg_core.sv ----
// timer run gating: start-on-trigger, stop-on-overflow, global timebase select,
// debug/doze pause, with an AXI4-Lite register face
// assumes trigger, debug, doze inputs asynchronous; global timebase on aclk
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module trg_core
    import trg_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // hardware trigger and chip modes
    input wire logic trigger_in,
    input wire logic debug_mode,
    input wire logic doze_mode,
    input wire logic capture_evt,
    // global timebase from peer
    input wire logic [CNT_W-1:0] gtb_count,
    // channel timebase and status
    output logic [CNT_W-1:0] chan_timebase,
    output logic capture_accept,
    output logic [CNT_W-1:0] local_count,
    output logic overflow_flag
);
    // elaboration check: the status word holds at most sixteen counter bits
    if (CNT_W < 2 || CNT_W > 16) begin : g_width_check
        $error("CNT_W must be 2..16");
    end

    typedef struct packed {
        logic [1:0] trig_sync;
        logic [1:0] dbg_sync;
        logic [1:0] doze_sync;
        logic [1:0] cap_sync;
        logic trig_prev;
        logic cap_prev;
        trg_run_t run;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] modulo;
        logic ovf;
        logic enable;
        logic soo;
        logic sot;
        logic gtb;
        logic [1:0] dbg;
        logic doze;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [3:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [CNT_W-1:0] tb;
        logic cap_acc;
    } trg_state_t;

    trg_state_t st_reg;
    trg_state_t st_next;

    // byte-lane merge, used for the config, control and modulo writes; the status write-one-clear tests wstrb[0] itself
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] cfg_word(input trg_state_t s);
        logic [31:0] w;
        w = CFG_RESET;
        w[CFG_SOO_BIT] = s.soo;
        w[CFG_SOT_BIT] = s.sot;
        w[CFG_GTB_BIT] = s.gtb;
        w[CFG_DBG_LO +: 2] = s.dbg;
        w[CFG_DOZE_BIT] = s.doze;
        return w;
    endfunction

    logic paused;
    logic ovf_hit;
    logic trig_edge;
    logic wr_fire;
    logic [31:0] cfg_m;
    logic [31:0] ctl_m;
    logic [31:0] mod_m;
    logic [31:0] rd_word;

    assign paused = (st_reg.dbg_sync[1] && st_reg.dbg != DBG_RUN)
        || (st_reg.doze_sync[1] && st_reg.doze);
    assign trig_edge = st_reg.trig_sync[1] && !st_reg.trig_prev && !paused;
    // counter wraps this cycle; a software clear of the flag must lose against it
    assign ovf_hit = st_reg.enable && st_reg.run == RS_COUNT && !paused && st_reg.cnt == st_reg.modulo;
    assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign cfg_m = merge(cfg_word(st_reg), st_reg.wdata, st_reg.wstrb);
    assign ctl_m = merge(32'(st_reg.enable) << CTL_EN_BIT, st_reg.wdata, st_reg.wstrb);
    assign mod_m = merge({{(32-CNT_W){1'b0}}, st_reg.modulo}, st_reg.wdata, st_reg.wstrb);

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            ADDR_CONFIG: rd_word = cfg_word(st_reg);
            ADDR_CONTROL: rd_word[CTL_EN_BIT] = st_reg.enable;
            ADDR_MODULO: rd_word[CNT_W-1:0] = st_reg.modulo;
            ADDR_STATUS: begin
                rd_word[ST_OVF_BIT] = st_reg.ovf;
                rd_word[ST_RUN_BIT] = (st_reg.run == RS_COUNT);
                rd_word[ST_STOP_BIT] = (st_reg.run == RS_STOPPED);
                rd_word[ST_PAUSE_BIT] = paused;
                rd_word[ST_CNT_LO +: CNT_W] = st_reg.cnt;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // ------------------------------------------------------------
        // synchronisers
        // ------------------------------------------------------------
        st_next.trig_sync = {st_reg.trig_sync[0], trigger_in};
        st_next.trig_prev = st_reg.trig_sync[1];
        st_next.dbg_sync = {st_reg.dbg_sync[0], debug_mode};
        st_next.doze_sync = {st_reg.doze_sync[0], doze_mode};
        st_next.cap_sync = {st_reg.cap_sync[0], capture_evt};
        st_next.cap_prev = st_reg.cap_sync[1];
        st_next.cap_acc = st_reg.cap_sync[1] && !st_reg.cap_prev && !paused;
        // ------------------------------------------------------------
        // run control and counter
        // ------------------------------------------------------------
        if (!st_reg.enable) begin
            st_next.run = RS_IDLE;
        end else begin
            unique case (st_reg.run)
                RS_IDLE: st_next.run = st_reg.sot ? RS_ARMED : RS_COUNT;
                RS_ARMED: if (trig_edge) st_next.run = RS_COUNT;
                RS_STOPPED: if (st_reg.sot && trig_edge) st_next.run = RS_COUNT;
                RS_COUNT: begin
                    if (!paused) begin
                        if (st_reg.cnt == st_reg.modulo) begin
                            st_next.cnt = '0;
                            st_next.ovf = 1'b1;
                            if (st_reg.soo) st_next.run = RS_STOPPED;
                        end else begin
                            st_next.cnt = st_reg.cnt + 1'b1;
                        end
                    end
                end
            endcase
        end
        st_next.tb = st_reg.gtb ? gtb_count : st_next.cnt;
        // ------------------------------------------------------------
        // axi4-lite write
        // ------------------------------------------------------------
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
            st_next.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
            st_next.wready = 1'b0;
        end
        if (wr_fire) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (st_reg.aw_addr)
                ADDR_CONFIG: begin
                    st_next.soo = cfg_m[CFG_SOO_BIT];
                    st_next.sot = cfg_m[CFG_SOT_BIT];
                    st_next.gtb = cfg_m[CFG_GTB_BIT];
                    st_next.dbg = cfg_m[CFG_DBG_LO +: 2];
                    st_next.doze = cfg_m[CFG_DOZE_BIT];
                end
                ADDR_CONTROL: st_next.enable = ctl_m[CTL_EN_BIT];
                ADDR_MODULO: st_next.modulo = mod_m[CNT_W-1:0];
                ADDR_STATUS: begin
                    // write one clears, a same-cycle overflow wins
                    if (st_reg.wstrb[0] && st_reg.wdata[ST_OVF_BIT] && !ovf_hit) begin
                        st_next.ovf = 1'b0;
                    end
                end
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        // ------------------------------------------------------------
        // axi4-lite read
        // ------------------------------------------------------------
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word;
            st_next.rresp = (s_axi_araddr > ADDR_STATUS || s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.modulo <= '1;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign chan_timebase = st_reg.tb;
    assign capture_accept = st_reg.cap_acc;
    assign local_count = st_reg.cnt;
    assign overflow_flag = st_reg.ovf;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);

    armed_holds_a: assert property (st_reg.run == RS_ARMED |=> $stable(st_reg.cnt))
        else $error("counter moved while armed");
    no_trig_start_a: assert property (st_reg.enable && st_reg.run == RS_IDLE && !st_reg.sot |=> st_reg.run == RS_COUNT)
        else $error("counter did not start without trigger");
    restart_trig_a: assert property (st_reg.enable && st_reg.run == RS_STOPPED && st_reg.sot && trig_edge
        |=> st_reg.run == RS_COUNT)
        else $error("trigger did not restart stopped counter");
    pause_trig_a: assert property (paused && (st_reg.run == RS_ARMED || st_reg.run == RS_STOPPED)
        |=> st_reg.run != RS_COUNT)
        else $error("trigger seen while paused");
    timebase_sel_a: assert property (st_reg.gtb && $stable(st_reg.gtb) |=> chan_timebase == $past(gtb_count))
        else $error("global timebase not selected");
    local_tb_a: assert property (!st_reg.gtb |=> chan_timebase == st_reg.cnt)
        else $error("local timebase not selected");
    ovf_sets_a: assert property (st_reg.run == RS_COUNT && st_reg.enable && !paused && st_reg.cnt == st_reg.modulo
        |=> overflow_flag && st_reg.cnt == '0)
        else $error("overflow not flagged");
    debug_pause_a: assert property (st_reg.dbg_sync[1] && st_reg.dbg == DBG_PAUSE |=> $stable(st_reg.cnt))
        else $error("counter moved in debug pause");
    doze_pause_a: assert property (st_reg.doze_sync[1] && st_reg.doze |=> $stable(st_reg.cnt) && !capture_accept)
        else $error("counter moved in doze pause");
    reserved_zero_a: assert property (st_reg.rvalid && $past(s_axi_araddr) == ADDR_CONFIG && $rose(st_reg.rvalid)
        |-> (st_reg.rdata & 32'hFFFC_FD1F) == 32'h0000_0000)
        else $error("reserved config bits nonzero");
    soo_stop_a: assert property (st_reg.run == RS_COUNT && st_reg.enable && st_reg.soo && !paused
        && st_reg.cnt == st_reg.modulo |=> st_reg.run == RS_STOPPED)
        else $error("counter did not stop on overflow");
    trig_delay_a: assert property (st_reg.enable && st_reg.run == RS_ARMED && !paused && !trigger_in ##1 trigger_in
        ##1 (trigger_in && st_reg.enable && !paused && st_reg.run == RS_ARMED) [*2]
        |=> st_reg.run == RS_COUNT)
        else $error("trigger response not three clocks");
    cover_trig_start: cover property (st_reg.run == RS_ARMED ##1 st_reg.run == RS_COUNT);
    cover_stop_restart: cover property (st_reg.run == RS_STOPPED ##[1:50] st_reg.run == RS_COUNT);
    cover_pause: cover property (paused && st_reg.run == RS_COUNT);
    cover_gtb: cover property (st_reg.gtb && overflow_flag);
endmodule

// ---- sim/trg_peer.sv ----
// far-side model: hardware trigger source and peer timer giving the global count
// assumes the bench pulses fire for one clock; shares the timer's clock
module trg_peer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench command
    input wire logic fire,
    // far-side outputs
    output logic trigger_in,
    output logic [CNT_W-1:0] gtb_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold_reg;
    // trigger held high five clocks so the synchroniser surely sees the rise
    assign trigger_in = hold_reg != 3'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_reg <= 3'h0;
            gtb_count <= CNT_W'(16'h0A5C);
        end else begin
            hold_reg <= fire ? 3'h5 : hold_reg - {2'h0, trigger_in};
            gtb_count <= gtb_count + CNT_W'(3);
        end
    end
endmodule

// ---- sim/timer_run_gating_config_bench.sv ----
// self-checking bench for the timer run gating block
// assumes trg_core and trg_peer compiled before it; one 100 MHz clock
module timer_run_gating_config_bench
    import trg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] wv; logic [31:0] rv;} trg_row_t;
    typedef struct {logic [31:0] cfg; logic dbg; logic dz; logic hold;} trg_pause_t;
    logic aclk = 1'b0;
    logic aresetn, clk_en, fire, trigger_in, debug_mode, doze_mode, capture_evt, capture_accept, overflow_flag;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] gtb_count, chan_timebase, local_count, v;
    int bad_count, checked, acc;
    trg_row_t rows[5] = '{'{32'hFFFF_FFFF, 32'h0003_02E0}, '{32'h0000_001F, 32'h0},
        '{32'h0000_FD00, 32'h0}, '{32'h0000_0200, 32'h0000_0200}, '{32'h0000_00C0, 32'h0000_00C0}};
    trg_pause_t pr[4] = '{'{32'h0, 1'b1, 1'b0, 1'b1}, '{32'hC0, 1'b1, 1'b0, 1'b0},
        '{32'h20, 1'b0, 1'b1, 1'b1}, '{32'h0, 1'b0, 1'b1, 1'b0}};

    always #5 aclk = ~aclk;
    trg_core dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trigger_in, .debug_mode, .doze_mode, .capture_evt,
        .gtb_count, .chan_timebase, .capture_accept, .local_count, .overflow_flag);
    trg_peer peer (.aclk, .aresetn, .fire, .trigger_in, .gtb_count);

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] wd);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse_trig();
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(20000);
        bad_count++;
        print_verdict();
    end
    initial begin
        {aresetn, fire, debug_mode, doze_mode, capture_evt} <= 5'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
        s_axi_wstrb <= 4'hF;
        clk_en <= 1'b1;
        tick(12);
        aresetn <= 1'b1;
        axr(ADDR_CONFIG);
        chk(d, CFG_RESET);
        foreach (rows[i]) begin
            axw(ADDR_CONFIG, rows[i].wv);
            axr(ADDR_CONFIG);
            chk(d, rows[i].rv);
        end
        axw(ADDR_CONFIG, 32'h0);
        axw(ADDR_MODULO, 32'h5);
        axw(ADDR_CONTROL, 32'h1);
        tick(3);
        v = local_count;
        tick(2);
        chk(32'(local_count != v), 32'h1);
        tick(1);
        chk(32'(chan_timebase), 32'(local_count));
        axw(ADDR_CONFIG, 32'h200);
        axw(ADDR_STATUS, 32'h1);
        tick(8);
        chk(32'(overflow_flag), 32'h1);
        tick(1);
        v = gtb_count;
        tick(1);
        chk(32'(chan_timebase), 32'(v));
        axw(ADDR_CONTROL, 32'h0);
        axw(ADDR_CONFIG, 32'h3_0000);
        axw(ADDR_CONTROL, 32'h1);
        tick(4);
        v = local_count;
        tick(10);
        chk(32'(local_count), 32'(v));
        pulse_trig();
        tick(4);
        chk(32'(local_count), 32'(v));
        tick(1);
        chk(32'(local_count != v), 32'h1);
        tick(20);
        chk(32'(local_count), 32'h0);
        axr(ADDR_STATUS);
        chk(d & 32'h5, 32'h5);
        debug_mode <= 1'b1;
        tick(5);
        pulse_trig();
        tick(10);
        chk(32'(local_count), 32'h0);
        debug_mode <= 1'b0;
        tick(5);
        chk(32'(local_count), 32'h0);
        pulse_trig();
        tick(6);
        chk(32'(local_count != 16'h0), 32'h1);
        axw(ADDR_CONTROL, 32'h0);
        axw(ADDR_CONFIG, 32'h0);
        axw(ADDR_MODULO, 32'hFF);
        axw(ADDR_CONTROL, 32'h1);
        // debug 00 and 11 only in the configuration writes below
        foreach (pr[i]) begin
            axw(ADDR_CONFIG, pr[i].cfg);
            debug_mode <= pr[i].dbg;
            doze_mode <= pr[i].dz;
            tick(5);
            v = local_count;
            capture_evt <= 1'b1;
            acc = 0;
            repeat (8) begin
                @(posedge aclk);
                capture_evt <= 1'b0;
                if (capture_accept === 1'b1) acc++;
            end
            chk(32'(local_count === v), 32'(pr[i].hold));
            chk(32'(acc), 32'(!pr[i].hold));
            debug_mode <= 1'b0;
            doze_mode <= 1'b0;
            tick(6);
            chk(32'(local_count - v < 16'h10 && local_count != v), 32'h1);
        end
        axw(4'h2, 32'hFFFF_FFFF);
        chk(32'(r), 32'(RESP_SLVERR));
        axr(4'h2);
        chk(d, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        // clock enable low freezes the running counter
        clk_en <= 1'b0;
        tick(2);
        v = local_count;
        tick(5);
        chk(32'(local_count), 32'(v));
        clk_en <= 1'b1;
        // second reset in mid-run
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        chk({15'h0, overflow_flag, local_count}, 32'h0);
        axr(ADDR_CONFIG);
        chk(d, CFG_RESET);
        print_verdict();
    end
endmodule
